// File: xafo_pkg.sv
// Package for the exclusive-OR accumulator/file execution block.
// Assumes a 12-bit instruction word, 8-bit data path and 5-bit file address.
package xafo_pkg;
   localparam int         XAFO_IW                            = 12;
   localparam int         XAFO_DW                            = 8;
   localparam int         XAFO_AW                            = 5;
   localparam int         XAFO_OPC_HI                        = 11;
   localparam int         XAFO_OPC_LO                        = 6;
   localparam int         XAFO_DEST_BIT                      = 5;
   localparam logic [5:0] XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE = 6'h06;
   localparam logic       XAFO_DEST_ACC                      = 1'h0;
   localparam logic       XAFO_DEST_FILE                     = 1'h1;
   localparam logic [7:0] XAFO_ACC_RESET                     = 8'h00;
   localparam logic [7:0] XAFO_ZERO                          = 8'h00;
   localparam int         XAFO_EXEC_CYCLES                   = 1;

   typedef struct packed {
      logic                 file_we;
      logic [XAFO_AW-1:0]   file_addr;
      logic [XAFO_DW-1:0]   file_data;
   } xafo_file_wr_s;
endpackage : xafo_pkg

// File: xafo_top.sv
// Execution logic for the exclusive-OR of accumulator with file register.
// Assumes the register file answers the read address combinationally and the
// decoder offers one instruction word per instruction cycle on CLK_IN.
`timescale 1ns/1ps

module xafo_top
   import xafo_pkg::*;
(
   input  wire logic                CLK_IN,
   input  wire logic                RESETN_IN,
   input  wire logic                INSTR_VALID_IN,
   input  wire logic [XAFO_IW-1:0]  INSTR_IN,
   input  wire logic [XAFO_DW-1:0]  FILE_RDATA_IN,
   output logic      [XAFO_AW-1:0]  FILE_RADDR_OUT,
   output logic                     FILE_WE_OUT,
   output logic      [XAFO_AW-1:0]  FILE_WADDR_OUT,
   output logic      [XAFO_DW-1:0]  FILE_WDATA_OUT,
   output logic      [XAFO_DW-1:0]  ACC_OUT,
   output logic                     ZERO_FLAG_OUT,
   output logic                     ZERO_WE_OUT,
   output logic                     DONE_OUT
);
   logic                reset_meta;
   logic                resetn;
   logic                hit;
   logic [XAFO_DW-1:0]  result;
   logic [XAFO_AW-1:0]  raddr;
   xafo_file_wr_s       next_wr;
   xafo_file_wr_s       wr;

   function automatic logic is_xor_op(input logic [XAFO_IW-1:0] w);
      return w[XAFO_OPC_HI:XAFO_OPC_LO] == XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE;
   endfunction : is_xor_op

   // Release of reset is retimed through two flops so every state flop leaves
   // reset on the same edge; entering reset still takes effect at once.
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         reset_meta <= 1'h0;
         resetn     <= 1'h0;
      end else begin
         reset_meta <= 1'h1;
         resetn     <= reset_meta;
      end
   end

   // The operand is fetched with the live address so the operation finishes in
   // one cycle; FILE_RADDR_OUT is only a registered mirror, one cycle late, for
   // observers such as a trace port.
   assign raddr  = INSTR_IN[XAFO_AW-1:0];
   assign hit    = INSTR_VALID_IN && is_xor_op(INSTR_IN);
   assign result = ACC_OUT ^ FILE_RDATA_IN;

   // Strobe, address and data travel in one struct so they are registered on
   // the same edge and can never disagree at the register file.
   always_comb begin
      next_wr.file_we   = hit && (INSTR_IN[XAFO_DEST_BIT] == XAFO_DEST_FILE);
      next_wr.file_addr = raddr;
      next_wr.file_data = result;
   end

   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         wr <= '0;
      end else begin
         wr <= next_wr;
      end
   end

   // A file-destination operation leaves the accumulator alone, so the next
   // operation still sees the old accumulator value.
   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         ACC_OUT <= XAFO_ACC_RESET;
      end else if (hit && INSTR_IN[XAFO_DEST_BIT] == XAFO_DEST_ACC) begin
         ACC_OUT <= result;
      end
   end

   // The pulses are plain copies of the decode hit, so back-to-back operations
   // give back-to-back pulses with no idle cycle between them.
   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         ZERO_WE_OUT <= 1'h0;
      end else begin
         ZERO_WE_OUT <= hit;
      end
   end

   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         DONE_OUT <= 1'h0;
      end else begin
         DONE_OUT <= hit;
      end
   end

   // The flag holds between operations and is judged on the result whichever
   // destination takes it.
   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         ZERO_FLAG_OUT <= 1'h0;
      end else if (hit) begin
         ZERO_FLAG_OUT <= (result == XAFO_ZERO);
      end
   end

   always_ff @(posedge CLK_IN or negedge resetn) begin
      if (!resetn) begin
         FILE_RADDR_OUT <= '0;
      end else begin
         FILE_RADDR_OUT <= raddr;
      end
   end

   assign FILE_WE_OUT    = wr.file_we;
   assign FILE_WADDR_OUT = wr.file_addr;
   assign FILE_WDATA_OUT = wr.file_data;

   // The checks below compare against the registered outputs one edge after
   // the cycle that triggers them; a_xor_value builds its expected value from ACC_OUT and FILE_RDATA_IN, a_raddr_mirror and a_dest_select from INSTR_IN,
   // while a_acc_write, a_file_write and a_zero_value take theirs from the internal result net.
   property p_acc_write;
      @(posedge CLK_IN) disable iff (!resetn)
      (hit && !INSTR_IN[XAFO_DEST_BIT]) |=> (ACC_OUT == $past(result)) && !FILE_WE_OUT;
   endproperty
   a_acc_write: assert property (p_acc_write) else $error("accumulator not written");

   property p_file_write;
      @(posedge CLK_IN) disable iff (!resetn)
      (hit && INSTR_IN[XAFO_DEST_BIT]) |=> FILE_WE_OUT && FILE_WDATA_OUT == $past(result)
         && FILE_WADDR_OUT == $past(raddr) && $stable(ACC_OUT);
   endproperty
   a_file_write: assert property (p_file_write) else $error("file not written");

   property p_xor_value;
      @(posedge CLK_IN) disable iff (!resetn)
      hit |=> DONE_OUT
         && ((($past(INSTR_IN[XAFO_DEST_BIT]) == XAFO_DEST_FILE) ? FILE_WDATA_OUT : ACC_OUT)
             == ($past(ACC_OUT) ^ $past(FILE_RDATA_IN)));
   endproperty
   a_xor_value: assert property (p_xor_value) else $error("bad xor result");

   property p_decode;
      @(posedge CLK_IN) disable iff (!resetn)
      (INSTR_VALID_IN && INSTR_IN[XAFO_OPC_HI:XAFO_OPC_LO] != XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE)
         |=> !DONE_OUT && !FILE_WE_OUT;
   endproperty
   a_decode: assert property (p_decode) else $error("wrong opcode executed");

   property p_one_cycle;
      @(posedge CLK_IN) disable iff (!resetn)
      DONE_OUT |-> $past(hit);
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("done without instruction");

   property p_zero_hold;
      @(posedge CLK_IN) disable iff (!resetn)
      !hit |=> $stable(ZERO_FLAG_OUT) && !ZERO_WE_OUT;
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved");

   property p_zero_value;
      @(posedge CLK_IN) disable iff (!resetn)
      hit |=> ZERO_FLAG_OUT == ($past(result) == XAFO_ZERO);
   endproperty
   a_zero_value: assert property (p_zero_value) else $error("zero flag wrong");

   property p_acc_hold;
      @(posedge CLK_IN) disable iff (!resetn)
      !(hit && !INSTR_IN[XAFO_DEST_BIT]) |=> $stable(ACC_OUT);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accumulator changed");

   property p_idle;
      @(posedge CLK_IN) disable iff (!resetn)
      !INSTR_VALID_IN |=> !DONE_OUT && !FILE_WE_OUT && !ZERO_WE_OUT;
   endproperty
   a_idle: assert property (p_idle) else $error("operation without valid word");

   property p_we_cause;
      @(posedge CLK_IN) disable iff (!resetn)
      FILE_WE_OUT |-> $past(INSTR_VALID_IN) && $past(INSTR_IN[XAFO_DEST_BIT]) == XAFO_DEST_FILE
         && $past(INSTR_IN[XAFO_OPC_HI:XAFO_OPC_LO]) == XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE;
   endproperty
   a_we_cause: assert property (p_we_cause) else $error("file write without cause");

   property p_zero_we_cause;
      @(posedge CLK_IN) disable iff (!resetn)
      ZERO_WE_OUT |-> $past(INSTR_VALID_IN)
         && $past(INSTR_IN[XAFO_OPC_HI:XAFO_OPC_LO]) == XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE;
   endproperty
   a_zero_we_cause: assert property (p_zero_we_cause) else $error("status load without cause");

   property p_zero_file_dest;
      @(posedge CLK_IN) disable iff (!resetn)
      (hit && INSTR_IN[XAFO_DEST_BIT] == XAFO_DEST_FILE) |=> ZERO_WE_OUT && ZERO_FLAG_OUT == (FILE_WDATA_OUT == XAFO_ZERO);
   endproperty
   a_zero_file_dest: assert property (p_zero_file_dest) else $error("zero flag wrong for file");

   property p_zero_acc_dest;
      @(posedge CLK_IN) disable iff (!resetn)
      (hit && INSTR_IN[XAFO_DEST_BIT] == XAFO_DEST_ACC) |=> ZERO_WE_OUT && ZERO_FLAG_OUT == (ACC_OUT == XAFO_ZERO);
   endproperty
   a_zero_acc_dest: assert property (p_zero_acc_dest) else $error("zero flag wrong for accumulator");

   property p_back_to_back;
      @(posedge CLK_IN) disable iff (!resetn)
      (hit ##1 hit) |=> DONE_OUT && $past(DONE_OUT);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("stall between operations");

   property p_raddr_mirror;
      @(posedge CLK_IN) disable iff (!resetn)
      INSTR_VALID_IN |=> FILE_RADDR_OUT == $past(INSTR_IN[XAFO_AW-1:0]);
   endproperty
   a_raddr_mirror: assert property (p_raddr_mirror) else $error("read address mirror wrong");

   property p_dest_select;
      @(posedge CLK_IN) disable iff (!resetn)
      hit |=> FILE_WE_OUT == $past(INSTR_IN[XAFO_DEST_BIT]);
   endproperty
   a_dest_select: assert property (p_dest_select) else $error("wrong destination chosen");
endmodule : xafo_top

// File: xafo_top_tb.sv
// Self-checking bench for the accumulator/file exclusive-OR block.
// Assumes outputs change only on CLK_IN rising edges; inputs move at falling edges.
`timescale 1ns/1ps
module xafo_top_tb;
   import xafo_pkg::*;
   logic               clk, rst_n, valid, we, zf, zwe, done, zf_m, take;
   logic [XAFO_IW-1:0] instr;
   logic [XAFO_DW-1:0] rdata, acc_m, res, wdata, acc;
   logic [XAFO_AW-1:0] raddr, waddr;
   logic [31:0]        seed;
   int                 fails, cmp_count, cycles;
   xafo_top i_dut (.CLK_IN(clk), .RESETN_IN(rst_n), .INSTR_VALID_IN(valid), .INSTR_IN(instr),
      .FILE_RDATA_IN(rdata), .FILE_RADDR_OUT(raddr), .FILE_WE_OUT(we), .FILE_WADDR_OUT(waddr),
      .FILE_WDATA_OUT(wdata), .ACC_OUT(acc), .ZERO_FLAG_OUT(zf), .ZERO_WE_OUT(zwe), .DONE_OUT(done));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] xor_res(input logic [7:0] a, input logic [7:0] f);
      return a ^ f;
   endfunction : xor_res
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("fails %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Drives one word at a falling edge and checks the answer one cycle later.
   task automatic step(input logic v, input logic [11:0] w, input logic [7:0] d);
      valid = v;
      instr = w;
      rdata = d;
      take = v && (w[XAFO_OPC_HI:XAFO_OPC_LO] === XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE);
      res = xor_res(acc_m, d);
      @(posedge clk);
      @(negedge clk);
      if (take && w[XAFO_DEST_BIT] == XAFO_DEST_ACC)
         acc_m = res;
      if (take)
         zf_m = (res == XAFO_ZERO);
      chk(16'(acc), 16'(acc_m));
      chk(16'(we), 16'(take && w[XAFO_DEST_BIT] == XAFO_DEST_FILE));
      if (take && w[XAFO_DEST_BIT] == XAFO_DEST_FILE)
         chk(16'({waddr, wdata}), 16'({w[XAFO_AW-1:0], res}));
      chk(16'({done, zwe}), 16'({take, take}));
      chk(16'(zf), 16'(zf_m));
      chk(16'(raddr), 16'(w[XAFO_AW-1:0]));
   endtask : step
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      valid = 1'h0;
      instr = '0;
      rdata = '0;
      rst_n = 1'h0;
      seed = 32'hb9b7;
      acc_m = XAFO_ACC_RESET;
      zf_m = 1'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
      chk(16'({acc, done, zwe, we, zf}), 16'({XAFO_ACC_RESET, 4'h0}));
      step(1'h1, 12'h183, 8'hb5);
      step(1'h1, 12'h1a3, 8'haf);
      step(1'h1, 12'h180, 8'hb5);
      step(1'h0, 12'h1bf, 8'h5a);
      step(1'h1, 12'h0ff, 8'h5a);
      step(1'h1, 12'h183, 8'h3c);
      step(1'h1, 12'h1bf, 8'h3c);
      for (int i = 0; i < 300; i++) begin
         seed = lfsr(seed);
         step(seed[0] | seed[1],
              {(seed[3:2] != 2'h0) ? XAFO_OPC_XOR_ACCUMULATOR_WITH_FILE : seed[9:4], seed[15:10]}, seed[31:24]);
      end
      test_done();
   end
endmodule : xafo_top_tb
